// ---- verilog/lcfc_top.sv ----
/*
  Segment display control register and operating/frame clock selection.
  Assumes clk_sys is the system clock, sub_clk_pin the asynchronous
  sub-clock, and the power-mode inputs come from logic on clk_sys.
*/
// Function
// - Top control bit reads one, writes ignored
// - Supply switch set connects drive supply
// - Inactive or standby forces supply isolated
// - Activate clear halts operation, registers kept
// - Display bit clear outputs blank data
// - Sub-clock selection: undivided, half, quarter
// - System clock selection: divide 2 to 256
// - System clock stopped with system clock selected means no display clock
// - One-third duty gives four-thirds frame rate
`timescale 1ns/1ps
`include "lcfc_regs.svh"
module lcfc_top (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic [`LCFC_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wr_data,
  input  wire logic                    reg_wr_stb,
  input  wire logic                    reg_rd_stb,
  output logic      [7:0]              reg_rd_data_q,
  input  wire logic                    sub_clk_pin,
  input  wire logic                    standby_mode,
  input  wire logic                    sys_clk_stopped,
  input  wire logic                    duty_one_third,
  output logic                         drive_supply_on_q,
  output logic                         show_ram_data_q,
  output logic                         ctrl_running_q,
  output logic                         display_clock_ok_q,
  output logic                         op_tick_q,
  output logic                         frame_tick_q,
  output logic                         lcd_alt_q
);
  import lcfc_pkg::*;

  logic                    drive_supply_switch_q;
  logic                    display_activate_q;
  logic                    display_data_select_q;
  lcfc_cks_t               frame_clk_sel_q;
  lcfc_cks_t               frame_clk_sel_prev_q;
  logic                    sub_s1_q;
  logic                    sub_s2_q;
  logic                    sub_s3_q;
  logic                    sub_level_q;
  logic                    third_prev_q;

  wire logic               ctrl_hit;
  wire logic               ctrl_wr;
  wire logic [7:0]         ctrl_rd;
  wire logic               sub_agree;
  wire logic               sub_rise;
  wire logic               sel_chg;
  wire lcfc_src_t          src;
  wire logic               src_tick;
  wire logic [`LCFC_PRE_W-1:0] pre_len;
  wire logic [`LCFC_FRM_W-1:0] frm_len;
  wire logic               pre_restart;
  wire logic               frm_restart;
  wire logic               supply_d;

  // Register decode
  assign ctrl_hit = (reg_addr == `LCFC_CTRL_OFS);
  assign ctrl_wr  = reg_wr_stb && ctrl_hit;
  assign ctrl_rd  = {1'b1, drive_supply_switch_q, display_activate_q,
                     display_data_select_q, frame_clk_sel_q};

  // Sub-clock edge once second and third stages agree
  assign sub_agree = (sub_s2_q == sub_s3_q);
  assign sub_rise  = sub_agree && sub_s3_q && !sub_level_q;

  // Clock source choice
  assign src = (standby_mode ||
                (frame_clk_sel_q[`LCFC_CKS_MSB] && sys_clk_stopped))
               ? LCFC_SRC_NONE
               : (frame_clk_sel_q[`LCFC_CKS_MSB] ? LCFC_SRC_SYS
                                                 : LCFC_SRC_SUB);

  assign src_tick = (src == LCFC_SRC_SUB) ? sub_rise :
                    (src == LCFC_SRC_SYS) ? 1'b1 : 1'b0;

  // Prescale length: sub 1/2/4, system 2..256
  assign pre_len = frame_clk_sel_q[`LCFC_CKS_MSB]
                 ? (9'h002 << frame_clk_sel_q[2:0])
                 : (frame_clk_sel_q[1] ? 9'h004
                                       : (frame_clk_sel_q[0] ? 9'h002
                                                             : 9'h001));

  // Frame length, shortened by a quarter for one-third duty
  assign frm_len = frame_clk_sel_q[`LCFC_CKS_MSB]
                 ? (duty_one_third ? `LCFC_FRM_SYS_3RD
                                   : `LCFC_FRM_SYS)
                 : (duty_one_third ? `LCFC_FRM_SUB_3RD
                                   : `LCFC_FRM_SUB);

  assign sel_chg     = (frame_clk_sel_q != frame_clk_sel_prev_q);
  assign pre_restart = !display_activate_q || sel_chg ||
                       (src == LCFC_SRC_NONE);
  assign frm_restart = pre_restart || (duty_one_third != third_prev_q);

  assign supply_d = drive_supply_switch_q && display_activate_q &&
                    !standby_mode;

  // Control register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drive_supply_switch_q <= 1'b0;
      display_activate_q    <= 1'b0;
      display_data_select_q <= 1'b0;
      frame_clk_sel_q       <= 4'h0;
    end else if (ctrl_wr) begin
      drive_supply_switch_q <= reg_wr_data[`LCFC_PSW_BIT];
      display_activate_q    <= reg_wr_data[`LCFC_ACT_BIT];
      display_data_select_q <= reg_wr_data[`LCFC_DISPLAY_DATA_SELECT_BIT];
      frame_clk_sel_q       <= reg_wr_data[`LCFC_CKS_MSB:0];
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rd_data_q <= 8'h00;
    end else begin
      reg_rd_data_q <= (reg_rd_stb && ctrl_hit) ? ctrl_rd : 8'h00;
    end
  end

  // Sub-clock synchroniser
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sub_s1_q    <= 1'b0;
      sub_s2_q    <= 1'b0;
      sub_s3_q    <= 1'b0;
      sub_level_q <= 1'b0;
    end else begin
      sub_s1_q <= sub_clk_pin;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
      if (sub_agree) begin
        sub_level_q <= sub_s3_q;
      end
    end
  end

  // Change trackers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frame_clk_sel_prev_q <= 4'h0;
      third_prev_q         <= 1'b0;
    end else begin
      frame_clk_sel_prev_q <= frame_clk_sel_q;
      third_prev_q         <= duty_one_third;
    end
  end

  // Status and drive outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drive_supply_on_q  <= 1'b0;
      show_ram_data_q    <= 1'b0;
      ctrl_running_q     <= 1'b0;
      display_clock_ok_q <= 1'b0;
    end else begin
      drive_supply_on_q  <= supply_d;
      show_ram_data_q    <= display_data_select_q &&
                            display_activate_q;
      ctrl_running_q     <= display_activate_q;
      display_clock_ok_q <= display_activate_q &&
                            (src != LCFC_SRC_NONE);
    end
  end

  // Alternation signal flips every frame
  always_ff @(posedge clk_sys) begin
    if (reset || !display_activate_q) begin
      lcd_alt_q <= 1'b0;
    end else if (frame_tick_q) begin
      lcd_alt_q <= !lcd_alt_q;
    end
  end

  // Operating clock enable
  lcfc_tick_div #(.W(`LCFC_PRE_W)) u_pre (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .restart  (pre_restart),
    .src_tick (src_tick),
    .div_len  (pre_len),
    .tick_q   (op_tick_q)
  );

  // Frame enable
  lcfc_tick_div #(.W(`LCFC_FRM_W)) u_frm (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .restart  (frm_restart),
    .src_tick (op_tick_q),
    .div_len  (frm_len),
    .tick_q   (frame_tick_q)
  );

  a_fixed_bit_one: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd_stb && ctrl_hit) |=> reg_rd_data_q[`LCFC_FIXED_BIT])
    else $error("fixed control bit read as zero");

  a_supply_on: assert property (
    @(posedge clk_sys) disable iff (reset)
    supply_d |=> drive_supply_on_q)
    else $error("drive supply not connected");

  a_supply_isolated: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!display_activate_q || standby_mode) |=> !drive_supply_on_q)
    else $error("drive supply connected while inactive");

  a_act_halts_frames: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!display_activate_q ##1 !display_activate_q)
      |=> (!op_tick_q && !frame_tick_q))
    else $error("divider ran while inactive");

  a_blank_data: assert property (
    @(posedge clk_sys) disable iff (reset)
    !display_data_select_q |=> !show_ram_data_q)
    else $error("ram data shown while blanked");

  a_sub_undivided: assert property (
    @(posedge clk_sys) disable iff (reset)
    (frame_clk_sel_q == 4'h0 && src_tick && !pre_restart) |=> op_tick_q)
    else $error("undivided sub-clock tick missed");

  a_sys_half: assert property (
    @(posedge clk_sys) disable iff (reset)
    (frame_clk_sel_q == 4'h8 && op_tick_q && !pre_restart)
      ##1 !pre_restart |=> op_tick_q)
    else $error("system clock half rate wrong");

  a_sys_stop_mute: assert property (
    @(posedge clk_sys) disable iff (reset)
    (frame_clk_sel_q[`LCFC_CKS_MSB] && sys_clk_stopped)
      |=> (!op_tick_q && !display_clock_ok_q))
    else $error("display clocked with system clock stopped");

  a_third_length: assert property (
    @(posedge clk_sys) disable iff (reset)
    (duty_one_third && !frame_clk_sel_q[`LCFC_CKS_MSB])
      |-> (frm_len == `LCFC_FRM_SUB_3RD))
    else $error("one-third duty frame length wrong");
endmodule : lcfc_top

// ---- verilog/lcfc_regs.svh ----
/*
  Register offset, field positions, reset value and divider counts of the
  frame clock control block.
  Assumes inclusion by bare name from the top-level design module.
*/
`ifndef LCFC_REGS_SVH
`define LCFC_REGS_SVH

`define LCFC_ADDR_W       8
`define LCFC_CTRL_OFS     8'h00
`define LCFC_CTRL_RST     8'h80
`define LCFC_FIXED_BIT    7
`define LCFC_PSW_BIT      6
`define LCFC_ACT_BIT      5
`define LCFC_DISPLAY_DATA_SELECT_BIT     4
`define LCFC_CKS_MSB      3
`define LCFC_PRE_W        9
`define LCFC_FRM_W        10
`define LCFC_FRM_SUB      10'h100
`define LCFC_FRM_SYS      10'h200
`define LCFC_FRM_SUB_3RD  10'h0c0
`define LCFC_FRM_SYS_3RD  10'h180

`endif

// ---- verilog/lcfc_pkg.sv ----
/*
  Types shared by the frame clock control block.
  Assumes the register header sits beside it.
*/
package lcfc_pkg;
  typedef enum logic [1:0] {
    LCFC_SRC_SUB  = 2'b00,
    LCFC_SRC_SYS  = 2'b01,
    LCFC_SRC_NONE = 2'b10
  } lcfc_src_t;

  typedef logic [3:0] lcfc_cks_t;
endpackage : lcfc_pkg

// ---- verilog/lcfc_tick_div.sv ----
/*
  Enable-pulse divider: one pulse every div_len source ticks.
  Assumes one clock, synchronous active-high reset, div_len above zero.
*/
`timescale 1ns/1ps
module lcfc_tick_div #(
  parameter int W = 9
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         restart,
  input  wire logic         src_tick,
  input  wire logic [W-1:0] div_len,
  output logic              tick_q
);
  import lcfc_pkg::*;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         wrap;

  assign wrap  = src_tick && (cnt_q == div_len - W'(1));
  assign cnt_d = wrap ? '0 : (src_tick ? cnt_q + W'(1) : cnt_q);

  always_ff @(posedge clk_sys) begin
    if (reset || restart) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= wrap;
    end
  end

  a_restart_clean: assert property (
    @(posedge clk_sys) disable iff (reset)
    restart |=> (!tick_q && cnt_q == '0))
    else $error("divider did not restart cleanly");

  a_tick_cause: assert property (
    @(posedge clk_sys) disable iff (reset)
    tick_q |-> $past(src_tick))
    else $error("divider pulse without source tick");
endmodule : lcfc_tick_div

// ---- dv/lcd_control_frame_clock_select_test.sv ----
/*
  Self-checking bench of the frame clock control block.
  Assumes the design files under verilog/ are compiled first.
*/
`timescale 1ns/1ps
module lcd_control_frame_clock_select_test;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        reg_wr_stb = 1'b0;
  logic        reg_rd_stb = 1'b0;
  logic        sub_clk_pin = 1'b0;
  logic        standby_mode = 1'b0;
  logic        sys_clk_stopped = 1'b0;
  logic        duty_one_third = 1'b0;
  logic [7:0]  reg_rd_data_q;
  logic        drive_supply_on_q;
  logic        show_ram_data_q;
  logic        ctrl_running_q;
  logic        display_clock_ok_q;
  logic        op_tick_q;
  logic        frame_tick_q;
  logic        lcd_alt_q;
  logic [7:0]  exp_q[$];
  logic        rd_d = 1'b0;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          sc_n = 0;
  int          g;
  logic        alt_v;
  logic [31:0] seed = 32'h5f4f9c0a;

  always #2.5 clk_sys = ~clk_sys;

  lcfc_top lcfc_top_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .reg_rd_data_q(reg_rd_data_q),
    .sub_clk_pin(sub_clk_pin), .standby_mode(standby_mode),
    .sys_clk_stopped(sys_clk_stopped), .duty_one_third(duty_one_third),
    .drive_supply_on_q(drive_supply_on_q),
    .show_ram_data_q(show_ram_data_q), .ctrl_running_q(ctrl_running_q),
    .display_clock_ok_q(display_clock_ok_q), .op_tick_q(op_tick_q),
    .frame_tick_q(frame_tick_q), .lcd_alt_q(lcd_alt_q)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Sub-clock pin, period 40 system cycles
  always @(posedge clk_sys) begin
    sc_n <= (sc_n == 19) ? 0 : sc_n + 1;
    if (sc_n == 19)
      sub_clk_pin <= ~sub_clk_pin;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end

  // Read results taken off the queue
  always @(posedge clk_sys) rd_d <= reg_rd_stb;
  always @(negedge clk_sys) begin
    if (rd_d && exp_q.size() > 0)
      chk("rd_data", reg_rd_data_q, exp_q.pop_front());
    else if (!reset)
      chk("rd_idle", reg_rd_data_q, 8'h00);
  end

  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    if (w) begin
      reg_wr_stb <= 1'b1;
      @(posedge clk_sys);
      reg_wr_stb <= 1'b0;
    end
    if (r) begin
      reg_rd_stb <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd_stb <= 1'b0;
    end
    @(posedge clk_sys);
  endtask : xfer

  task automatic lv(input logic [3:0] e);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("supply", drive_supply_on_q, e[3]);
    chk("show", show_ram_data_q, e[2]);
    chk("running", ctrl_running_q, e[1]);
    chk("clk_ok", display_clock_ok_q, e[0]);
  endtask : lv

  task automatic gap(input logic frm, output int n);
    int w;
    w = 0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      w++;
    end while ((frm ? frame_tick_q : op_tick_q) !== 1'b1 && w < 3000);
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((frm ? frame_tick_q : op_tick_q) !== 1'b1 && n < 3000);
  endtask : gap

  task automatic tk(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (op_tick_q === 1'b1)
        c++;
    end
  endtask : tk

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    xfer(0, 1, 8'h00, 8'h00, 8'h80);
    xfer(1, 1, 8'h00, 8'h7f, 8'hff);
    xfer(1, 1, 8'h00, 8'h00, 8'h80);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      xfer(1, 1, 8'h00, seed[7:0], seed[7:0] | 8'h80);
      xfer(1, 1, {seed[15:9], 1'b1}, seed[23:16], 8'h00);
      xfer(0, 1, 8'h00, 8'h00, seed[7:0] | 8'h80);
    end
    xfer(1, 0, 8'h00, 8'h68, 8'h00);
    lv(4'b1011);
    @(posedge clk_sys);
    standby_mode <= 1'b1;
    lv(4'b0010);
    @(posedge clk_sys);
    standby_mode <= 1'b0;
    xfer(1, 1, 8'h00, 8'h48, 8'hc8);
    lv(4'b0000);
    tk(200, g);
    chk("halt_ticks", g, 0);
    chk("alt_halt", lcd_alt_q, 1'b0);
    xfer(1, 0, 8'h00, 8'h38, 8'h00);
    lv(4'b0111);
    for (int k = 0; k < 8; k++) begin
      xfer(1, 0, 8'h00, 8'h28 | k[7:0], 8'h00);
      gap(1'b0, g);
      chk("sys_gap", g, 2 << k);
    end
    xfer(1, 0, 8'h00, 8'h28, 8'h00);
    gap(1'b1, g);
    chk("frame_gap", g, 1024);
    alt_v = lcd_alt_q;
    @(posedge clk_sys);
    #1;
    chk("alt_flip", lcd_alt_q, !alt_v);
    @(posedge clk_sys);
    duty_one_third <= 1'b1;
    gap(1'b1, g);
    chk("frame_3rd", g, 768);
    @(posedge clk_sys);
    duty_one_third <= 1'b0;
    sys_clk_stopped <= 1'b1;
    lv(4'b0010);
    tk(600, g);
    chk("stop_ticks", g, 0);
    for (int s = 0; s < 8; s++) begin
      xfer(1, 0, 8'h00, 8'h20 | s[7:0], 8'h00);
      duty_one_third <= s[2];
      gap(1'b0, g);
      chk("sub_gap", g, s[1] ? 160 : (s[0] ? 80 : 40));
    end
    lv(4'b0011);
    wrap_up();
  end
endmodule : lcd_control_frame_clock_select_test
